// file: rtl/bcs_regs.svh
// constants of the brake control sequencer: parameter subindices, reset values, limits
// assumes a single 125 MHz core clock and a millisecond time base derived from it
// Functional notes
// - After standstill the brake is commanded closed only once the close-brake idle time has run.
// - After the brake is commanded closed, current goes off once the shutdown idle time has run.
// - On power-up current goes on first, and the brake opens after the open-brake delay.
// - After the brake opens, operation-enabled waits the start delay, which resets to zero.
// - The brake output pulses at the frequency in hertz, accepted 0 to 2000, reset value zero.
// - The PWM high time follows the duty in percent, accepted 0 or 2 to 100, reset value zero.
// - Subindex zero is a read-only 8-bit entry that returns 6.
// - All four timing parameters count milliseconds of the sequencer time base.
`ifndef BCS_REGS_SVH
`define BCS_REGS_SVH
`define BCS_SUB_COUNT      8'h00
`define BCS_SUB_CLOSE      8'h01
`define BCS_SUB_OFF        8'h02
`define BCS_SUB_OPEN       8'h03
`define BCS_SUB_START      8'h04
`define BCS_SUB_FREQ       8'h05
`define BCS_SUB_DUTY       8'h06
`define BCS_ENTRY_COUNT    8'h06
`define BCS_RST_CLOSE      32'h0000_03e8
`define BCS_RST_OFF        32'h0000_03e8
`define BCS_RST_OPEN       32'h0000_03e8
`define BCS_RST_START      32'h0000_0000
`define BCS_RST_FREQ       32'h0000_0000
`define BCS_RST_DUTY       32'h0000_0000
`define BCS_FREQ_MAX       32'h0000_07d0
`define BCS_DUTY_MIN       32'h0000_0002
`define BCS_DUTY_MAX       32'h0000_0064
`define BCS_PCT_FULL       64'h0000_0000_0000_0064
`define BCS_CLK_MHZ        125
`define BCS_CLK_HZ         32'h0773_5940
`define BCS_TICK_US        1000
`define BCS_CYC_PER_MS     (`BCS_TICK_US * `BCS_CLK_MHZ)
`endif

// file: rtl/bcs_pkg.sv
// types of the brake control sequencer
// assumes bcs_regs.svh for all numeric constants
package bcs_pkg;
  typedef struct packed {
    logic        wr;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } bcs_od_req_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_OPEN_WAIT,
    ST_RUN_WAIT,
    ST_RUN,
    ST_CLOSE_WAIT,
    ST_OFF_WAIT
  } bcs_state_t;
endpackage

// file: rtl/bcs_top.sv
// brake control sequencer: parameter array access, power/brake timing, brake PWM
// assumes enable_req and motor_standstill come from logic on core_clk
`timescale 1ns/1ps
`include "bcs_regs.svh"
module bcs_top #(
  parameter int unsigned CYC_PER_MS = `BCS_CYC_PER_MS
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rstn,
  // parameter array access
  input  wire logic               od_valid,
  input  wire bcs_pkg::bcs_od_req_t od_req,
  output logic                    od_ack_q,
  output logic                    od_err_q,
  output logic [31:0]             od_rdata_q,
  // power state side
  input  wire logic               enable_req,
  input  wire logic               motor_standstill,
  output logic                    motor_current_on_q,
  output logic                    op_enabled_q,
  // brake side
  output logic                    brake_open_q,
  output logic                    brake_out_q
);

  logic [31:0] close_q, off_q, open_q, start_q, freq_q, duty_q;
  logic        wr_ok;
  logic [31:0] rd_val;
  logic        sub_ok;

  // parameter writes; out-of-range values are refused and leave the entry unchanged
  always_comb begin
    wr_ok  = 1'b1;
    sub_ok = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (od_req.sub)
      `BCS_SUB_COUNT: begin
        rd_val = {24'h00_0000, `BCS_ENTRY_COUNT};
        wr_ok  = 1'b0;
      end
      `BCS_SUB_CLOSE: rd_val = close_q;
      `BCS_SUB_OFF:   rd_val = off_q;
      `BCS_SUB_OPEN:  rd_val = open_q;
      `BCS_SUB_START: rd_val = start_q;
      `BCS_SUB_FREQ: begin
        rd_val = freq_q;
        wr_ok  = od_req.wdata <= `BCS_FREQ_MAX;
      end
      `BCS_SUB_DUTY: begin
        rd_val = duty_q;
        wr_ok  = (od_req.wdata == 32'h0000_0000) || ((od_req.wdata >= `BCS_DUTY_MIN)
                 && (od_req.wdata <= `BCS_DUTY_MAX));
      end
      default: begin
        sub_ok = 1'b0;
        wr_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      close_q <= `BCS_RST_CLOSE;
      off_q   <= `BCS_RST_OFF;
      open_q  <= `BCS_RST_OPEN;
      start_q <= `BCS_RST_START;
      freq_q  <= `BCS_RST_FREQ;
      duty_q  <= `BCS_RST_DUTY;
    end else if (od_valid && od_req.wr && wr_ok) begin
      unique case (od_req.sub)
        `BCS_SUB_CLOSE: close_q <= od_req.wdata;
        `BCS_SUB_OFF:   off_q   <= od_req.wdata;
        `BCS_SUB_OPEN:  open_q  <= od_req.wdata;
        `BCS_SUB_START: start_q <= od_req.wdata;
        `BCS_SUB_FREQ:  freq_q  <= od_req.wdata;
        `BCS_SUB_DUTY:  duty_q  <= od_req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      od_ack_q   <= 1'b0;
      od_err_q   <= 1'b0;
      od_rdata_q <= 32'h0000_0000;
    end else begin
      od_ack_q   <= od_valid;
      od_err_q   <= od_valid && (od_req.wr ? !wr_ok : !sub_ok);
      od_rdata_q <= (od_valid && !od_req.wr) ? rd_val : 32'h0000_0000;
    end
  end

  // millisecond time base
  logic [31:0] div_q, ms_q;
  logic        tick, tmr_clr;
  assign tick = div_q == 32'(CYC_PER_MS - 1);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 32'h0000_0000;
      ms_q  <= 32'h0000_0000;
    end else if (tmr_clr) begin
      div_q <= 32'h0000_0000;
      ms_q  <= 32'h0000_0000;
    end else begin
      div_q <= tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
      // saturate so a huge delay can never wrap to an early expiry
      if (tick && ms_q != 32'hffff_ffff)
        ms_q <= ms_q + 32'h0000_0001;
    end
  end

  // sequencer
  bcs_pkg::bcs_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      bcs_pkg::ST_OFF:
        if (enable_req) state_d = bcs_pkg::ST_OPEN_WAIT;
      bcs_pkg::ST_OPEN_WAIT:
        if (!enable_req) state_d = bcs_pkg::ST_OFF_WAIT;
        else if (ms_q >= open_q) state_d = bcs_pkg::ST_RUN_WAIT;
      bcs_pkg::ST_RUN_WAIT:
        if (!enable_req) state_d = bcs_pkg::ST_CLOSE_WAIT;
        else if (ms_q >= start_q) state_d = bcs_pkg::ST_RUN;
      bcs_pkg::ST_RUN:
        if (!enable_req) state_d = bcs_pkg::ST_CLOSE_WAIT;
      bcs_pkg::ST_CLOSE_WAIT:
        if (motor_standstill && ms_q >= close_q) state_d = bcs_pkg::ST_OFF_WAIT;
      bcs_pkg::ST_OFF_WAIT:
        if (ms_q >= off_q) state_d = bcs_pkg::ST_OFF;
    endcase
  end

  // close-brake idle time restarts whenever the motor moves again
  assign tmr_clr = (state_d != state_q) ||
                   (state_q == bcs_pkg::ST_CLOSE_WAIT && !motor_standstill);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q            <= bcs_pkg::ST_OFF;
      motor_current_on_q <= 1'b0;
      brake_open_q       <= 1'b0;
      op_enabled_q       <= 1'b0;
    end else begin
      state_q            <= state_d;
      motor_current_on_q <= state_d != bcs_pkg::ST_OFF;
      brake_open_q       <= state_d == bcs_pkg::ST_RUN_WAIT || state_d == bcs_pkg::ST_RUN ||
                            state_d == bcs_pkg::ST_CLOSE_WAIT;
      op_enabled_q       <= state_d == bcs_pkg::ST_RUN;
    end
  end

  // brake pwm by phase accumulator, avoids a divider for the period
  logic [31:0] acc_q, acc_sum;
  logic        pwm_hi, pwm_static;
  assign acc_sum    = acc_q + freq_q;
  assign pwm_hi     = ({32'h0000_0000, acc_q} * `BCS_PCT_FULL) <
                      ({32'h0000_0000, duty_q} * {32'h0000_0000, `BCS_CLK_HZ});
  assign pwm_static = (freq_q == 32'h0000_0000) || (duty_q == 32'h0000_0000);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acc_q <= 32'h0000_0000;
    end else if (!brake_open_q || pwm_static) begin
      acc_q <= 32'h0000_0000;
    end else begin
      acc_q <= (acc_sum >= `BCS_CLK_HZ) ? acc_sum - `BCS_CLK_HZ : acc_sum;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) brake_out_q <= 1'b0;
    else brake_out_q <= brake_open_q && (pwm_static || pwm_hi);
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_close_after_idle: assert property ($fell(brake_open_q) |->
    $past(ms_q) >= $past(close_q) && $past(motor_standstill))
    else $error("brake closed before close idle time");
  a_off_after_close: assert property ($fell(motor_current_on_q) |->
    !$past(brake_open_q) && $past(ms_q) >= $past(off_q))
    else $error("current off before shutdown idle time");
  a_open_after_cur: assert property ($rose(brake_open_q) |->
    $past(motor_current_on_q) && $past(ms_q) >= $past(open_q))
    else $error("brake opened too early");
  a_run_after_delay: assert property ($rose(op_enabled_q) |->
    $past(brake_open_q) && $past(ms_q) >= $past(start_q))
    else $error("operation enabled before start delay");
  a_freq_range: assert property (od_valid && od_req.wr && od_req.sub == `BCS_SUB_FREQ &&
    od_req.wdata > `BCS_FREQ_MAX |=> od_err_q && $stable(freq_q))
    else $error("out of range frequency accepted");
  a_duty_range: assert property (od_valid && od_req.wr && od_req.sub == `BCS_SUB_DUTY &&
    od_req.wdata == 32'h0000_0001 |=> od_err_q && $stable(duty_q))
    else $error("duty of one accepted");
  a_count_read: assert property (od_valid && !od_req.wr && od_req.sub == `BCS_SUB_COUNT
    |=> od_ack_q && !od_err_q && od_rdata_q == 32'h0000_0006)
    else $error("entry count not six");
  a_ms_tick: assert property (tick && !tmr_clr |=> div_q == 32'h0000_0000)
    else $error("ms divider did not wrap");
  a_static_brake: assert property (brake_open_q && pwm_static |=> brake_out_q)
    else $error("static brake output not active");
  a_brake_idle: assert property (!brake_open_q |=> !brake_out_q)
    else $error("brake driven while closed");
  // brake may only be open while current flows
  a_brake_needs_cur: assert property (brake_open_q |-> motor_current_on_q)
    else $error("brake open without motor current");
  a_ms_advance: assert property (tick && !tmr_clr && ms_q != 32'hffff_ffff |=>
    ms_q == $past(ms_q) + 32'h0000_0001)
    else $error("ms counter did not advance");
  a_od_answer: assert property (od_valid |=> od_ack_q)
    else $error("parameter access not answered");

  c_power_up: cover property ($rose(op_enabled_q));
  c_shutdown: cover property ($fell(motor_current_on_q));
  c_pwm_pulse: cover property (brake_open_q && !pwm_static && $fell(brake_out_q));
  c_bad_write: cover property (od_err_q);
  c_open_abort: cover property (state_q == bcs_pkg::ST_OPEN_WAIT && !enable_req);

endmodule // bcs_top

// file: sim/bcs_partner.sv
// brake driver and power stage stand-in: motor rest flag, brake pulse timing
// assumes the sequencer outputs change on core_clk
`timescale 1ns/1ps
module bcs_partner (
  // clock
  input  wire logic core_clk,
  // from sequencer
  input  wire logic op_enabled_q,
  input  wire logic brake_out_q,
  // to sequencer
  output logic      motor_standstill,
  // pulse measurements
  output int        hi_len,
  output int        lo_len,
  output int        edges
);
  int   run;
  int   coast;
  logic last;
  initial begin
    motor_standstill = 1'b1;
    edges = 0;
    run = 0;
    coast = 5;
    last = 1'b0;
  end
  // motor coasts a few cycles before it is at rest
  always @(posedge core_clk) begin
    coast <= op_enabled_q ? 0 : (coast < 5 ? coast + 1 : coast);
    motor_standstill <= !op_enabled_q && coast >= 4;
    last <= brake_out_q;
    run <= (brake_out_q != last) ? 1 : run + 1;
    if (brake_out_q != last) begin
      edges <= edges + 1;
      if (brake_out_q) lo_len <= run;
      else hi_len <= run;
    end
  end
endmodule // bcs_partner

// file: sim/bcs_top_tb.sv
// self-checking bench of the brake control sequencer
// assumes bcs_top, bcs_pkg and bcs_partner are compiled first
`timescale 1ns/1ps
`include "bcs_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; \
  if ((e) !== (g)) begin n_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module bcs_top_tb;
  localparam int CYC = 10;
  logic                 core_clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 od_valid = 1'b0;
  bcs_pkg::bcs_od_req_t od_req = '0;
  logic                 od_ack_q, od_err_q, enable_req = 1'b0, motor_standstill;
  logic [31:0]          od_rdata_q;
  logic                 motor_current_on_q, op_enabled_q, brake_open_q, brake_out_q;
  int                   hi_len, lo_len, edges, n, e0, n_errors = 0, samples_checked = 0;
  logic [31:0]          rnd = 32'h1552_7611;
  logic [31:0]          mdl [0:6] = '{32'h0000_0006, `BCS_RST_CLOSE, `BCS_RST_OFF,
                                      `BCS_RST_OPEN, `BCS_RST_START, `BCS_RST_FREQ, `BCS_RST_DUTY};
  always #4 core_clk = ~core_clk;
  bcs_top #(.CYC_PER_MS(CYC)) uut (.core_clk(core_clk), .rstn(rstn), .od_valid(od_valid),
    .od_req(od_req), .od_ack_q(od_ack_q), .od_err_q(od_err_q), .od_rdata_q(od_rdata_q),
    .enable_req(enable_req), .motor_standstill(motor_standstill),
    .motor_current_on_q(motor_current_on_q), .op_enabled_q(op_enabled_q),
    .brake_open_q(brake_open_q), .brake_out_q(brake_out_q));
  bcs_partner far (.core_clk(core_clk), .op_enabled_q(op_enabled_q), .brake_out_q(brake_out_q),
    .motor_standstill(motor_standstill), .hi_len(hi_len), .lo_len(lo_len), .edges(edges));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // counts may land a cycle early or a few late because of input registering
  function automatic logic inr(input int c, input logic [31:0] ms);
    return (c + 1 >= ms * CYC) && (c <= ms * CYC + 3);
  endfunction
  task automatic results();
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic od(input logic w, input logic [7:0] s, input logic [31:0] d, input logic er);
    @(negedge core_clk);
    od_valid = 1'b1;
    od_req = '{wr: w, sub: s, wdata: d};
    @(negedge core_clk);
    // answer stands for the one cycle after the taking edge
    od_valid = 1'b0;
    `CHK("od_ack", 1'b1, od_ack_q)
    `CHK("od_err", er, od_err_q)
    `CHK("od_rdata", (!w && !er) ? mdl[s] : 32'h0000_0000, od_rdata_q)
    if (w && !er) mdl[s] = d;
  endtask
  task automatic waitfor(input int which, input logic lvl, output int c);
    logic v;
    c = 0;
    do begin
      @(negedge core_clk);
      c++;
      case (which)
        0: v = motor_current_on_q;
        1: v = brake_open_q;
        2: v = op_enabled_q;
        default: v = motor_standstill;
      endcase
    end while (v !== lvl && c < 2000);
    if (c >= 2000) begin
      n_errors++;
      results();
    end
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk) rstn = 1'b1;
    for (int s = 0; s < 7; s++) od(1'b0, s[7:0], 32'h0, 1'b0);
    od(1'b0, 8'h07, 32'h0, 1'b1);
    od(1'b1, 8'h00, 32'h0000_0009, 1'b1);
    od(1'b1, 8'h05, 32'h0000_07d1, 1'b1);
    od(1'b1, 8'h06, 32'h0000_0001, 1'b1);
    od(1'b1, 8'h06, 32'h0000_0065, 1'b1);
    for (int i = 1; i < 5; i++) begin
      rnd = xs(rnd);
      od(1'b1, 8'(i), {30'h0, rnd[1:0]} + 32'h1, 1'b0);
    end
    for (int s = 0; s < 7; s++) od(1'b0, s[7:0], 32'h0, 1'b0);
    @(negedge core_clk) enable_req = 1'b1;
    waitfor(0, 1'b1, n);
    `CHK("brake_early", 1'b0, brake_open_q)
    waitfor(1, 1'b1, n);
    `CHK("open_delay", 1'b1, inr(n, mdl[3]))
    waitfor(2, 1'b1, n);
    `CHK("start_delay", 1'b1, inr(n, mdl[4]))
    repeat (3) @(negedge core_clk);
    repeat (20) begin
      @(negedge core_clk);
      `CHK("brake_static", 1'b1, brake_out_q)
    end
    @(negedge core_clk) enable_req = 1'b0;
    waitfor(2, 1'b0, n);
    waitfor(3, 1'b1, n);
    waitfor(1, 1'b0, n);
    `CHK("close_delay", 1'b1, inr(n, mdl[1]))
    `CHK("current_held", 1'b1, motor_current_on_q)
    waitfor(0, 1'b0, n);
    `CHK("off_delay", 1'b1, inr(n, mdl[2]))
    // drop the request during the open delay: brake must never open
    e0 = edges;
    @(negedge core_clk) enable_req = 1'b1;
    waitfor(0, 1'b1, n);
    @(negedge core_clk) enable_req = 1'b0;
    waitfor(0, 1'b0, n);
    `CHK("abort_off_delay", 1'b1, inr(n, mdl[2]))
    `CHK("abort_brake_shut", e0, edges)
    od(1'b1, 8'h05, 32'h0000_07d0, 1'b0);
    od(1'b1, 8'h06, 32'h0000_000a, 1'b0);
    @(negedge core_clk) enable_req = 1'b1;
    waitfor(1, 1'b1, n);
    repeat (2) @(negedge core_clk);
    e0 = edges;
    for (n = 0; edges < e0 + 3 && n < 80000; n++) @(negedge core_clk);
    `CHK("pulse_seen", 1'b1, n < 80000)
    e0 = 125000000 / 2000;
    `CHK("pulse_high", 1'b1, hi_len >= e0 / 10 - 2 && hi_len <= e0 / 10 + 2)
    `CHK("pulse_period", 1'b1, hi_len + lo_len >= e0 - 2 && hi_len + lo_len <= e0 + 2)
    results();
  end
endmodule // bcs_top_tb
